// [usb_ps2_status_control_regs.sv]
// USB/PS2 status and control register bank with Avalon-MM slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`default_nettype none
module usb_ps2_status_control_regs
   import usb_ps2_regs_pkg::*;
#(
   parameter int RESUME_HOLD = RESUME_HOLD_CYCLES
) (
   input wire logic core_clk, // 200 MHz system clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall until answer
   input wire sie_status_t sie_status, // Engine status, same clock
   input wire logic usb_int_enable, // Processor USB interrupt enable
   input wire logic stack_full, // Processor call stack full
   input wire logic data_pin_in, // D-/DATA pin level, async
   input wire logic clock_pin_in, // D+/CLK pin level, async
   output pin_drive_t pin_drive, // Pin drive, enables active low
   output logic remote_wakeup_cmd, // Wakeup command to engine
   output logic ps2_select, // PS2 operation selected
   output logic usb_select, // USB operation selected
   output logic converter_ref_internal, // Converter on internal rails
   output logic fifo_write_dir, // Emulator FIFO direction
   output logic usb_clock_gate, // USB clock enable
   output logic deep_idle_power_save, // Deep suspend power save
   output logic usb_irq // Level interrupt
);

   // Address decode shared by read mux and write strobes
   function automatic logic reg_hit(input logic [7:0] addr,
                                    input logic [5:0] idx);
      reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   // Bus handshake state and the latched read answer
   logic wait_reg;
   logic [31:0] rdata_reg;
   // Two flip-flops per shared pin
   logic [1:0] pin_meta_reg;
   logic [1:0] pin_sync_reg;
   // Engine history for edge detection and the flags built from it
   logic idle_prev_reg;
   logic reset_prev_reg;
   logic bus_reset_flag_reg;
   // Resume visibility timer
   logic resume_flag_reg;
   logic [RESUME_CNT_W-1:0] resume_cnt_reg;
   // Software-written register images
   logic [7:0] ctrl_wr_reg;
   logic [7:0] endpoint_reg;
   logic [7:0] clock_ctrl_reg;
   // Sticky events, their mask and the interrupt level
   logic [EV_COUNT-1:0] event_status_reg;
   logic [EV_COUNT-1:0] event_mask_reg;
   logic irq_reg;
   // Registered pin drive
   pin_drive_t pin_drive_reg;

   // Accepted access strobes; a write needs byte lane 0 set
   wire logic req = avs_read | avs_write;
   wire logic accept = req & ~wait_reg;
   wire logic lane0 = avs_byteenable[0];
   wire logic wr_ctrl = accept & avs_write & lane0 &
                        reg_hit(avs_address, IDX_USB_PS2_CTRL_STATUS);
   wire logic wr_endp = accept & avs_write & lane0 &
                        reg_hit(avs_address, IDX_ENDPOINT_IRQ_STATUS);
   wire logic wr_clk = accept & avs_write & lane0 &
                       reg_hit(avs_address, IDX_CLOCK_CONTROL);
   wire logic wr_mask = accept & avs_write & lane0 &
                        reg_hit(avs_address, IDX_EVENT_MASK);
   wire logic rd_event = accept & avs_read &
                         reg_hit(avs_address, IDX_EVENT_STATUS);

   // Two-stage synchronisers for the shared pins
   // They reset to the pull-up level, so no false pin edge follows reset
   wire logic [1:0] pin_raw = {clock_pin_in, data_pin_in};
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_meta_reg[g] <= 1'b1;
               pin_sync_reg[g] <= 1'b1;
            end else begin
               pin_meta_reg[g] <= pin_raw[g];
               pin_sync_reg[g] <= pin_meta_reg[g];
            end
         end
      end
   endgenerate

   // Engine event detection
   // Engine inputs share this clock and need no synchroniser
   wire logic idle_now = sie_status.bus_idle;
   wire logic idle_change = idle_now ^ idle_prev_reg;
   wire logic idle_leave = idle_prev_reg & ~idle_now;
   wire logic reset_rise = sie_status.usb_reset & ~reset_prev_reg;
   wire logic [3:0] ep_hit = sie_status.endpoint_hit;
   wire logic ep_event = (|ep_hit) & usb_int_enable & ~stack_full;

   // Resume flag: set on leaving suspend, held for the visibility time
   // A fresh exit restarts the timer; re-entering suspend cuts it short
   wire logic resume_done = resume_flag_reg &&
      (resume_cnt_reg == RESUME_CNT_W'(RESUME_HOLD - 1));
   wire logic resume_next = idle_leave | (resume_flag_reg & ~resume_done
                            & ~idle_now);
   wire logic [RESUME_CNT_W-1:0] resume_cnt_next =
      (idle_leave | ~resume_flag_reg) ? '0 : resume_cnt_reg + 1'b1;

   // Control bits software may write in the control/status register
   // Command and pin-drive bits are write-only and read back as zero
   wire logic [7:0] ctrl_wr_mask = (8'h01 << BIT_REMOTE_WAKEUP_CMD) |
                                   (8'h01 << BIT_PS2_DATA_OUT) |
                                   (8'h01 << BIT_PS2_CLOCK_OUT);
   wire logic [7:0] ctrl_wr_next = wr_ctrl ?
      (avs_writedata[7:0] & ctrl_wr_mask) : ctrl_wr_reg;

   // Endpoint flags: firmware writes, engine hits win over a clear
   // A hit in the cycle of a clear is kept, so no access is lost
   wire logic [7:0] endpoint_wr = wr_endp ? avs_writedata[7:0]
                                          : endpoint_reg;
   wire logic [7:0] endpoint_next = {endpoint_wr[7:4],
                                     endpoint_wr[3:0] | ep_hit};

   // Only the clock gate and deep save bits are stored
   wire logic [7:0] clock_ctrl_next = wr_clk ?
      (avs_writedata[7:0] & 8'h18) : clock_ctrl_reg;

   // Sticky events: a read clears only what it reported, sets win
   // An event arriving during the clearing read stays pending
   logic [EV_COUNT-1:0] event_set;
   assign event_set[EV_IDLE_CHANGE] = idle_change;
   assign event_set[EV_BUS_RESET] = reset_rise;
   assign event_set[EV_RESUME] = idle_leave;
   assign event_set[EV_ENDPOINT] = ep_event;
   wire logic [EV_COUNT-1:0] event_clr = rd_event ?
      rdata_reg[EV_COUNT-1:0] : '0;
   wire logic [EV_COUNT-1:0] event_status_next =
      (event_status_reg & ~event_clr) | event_set;
   wire logic [EV_COUNT-1:0] event_mask_next = wr_mask ?
      avs_writedata[EV_COUNT-1:0] : event_mask_reg;

   // Live status view of the control/status register
   // The suspend bit shows the registered copy used for edge detection
   logic [7:0] ctrl_view;
   assign ctrl_view[BIT_BUS_IDLE_FLAG] = idle_prev_reg;
   assign ctrl_view[BIT_REMOTE_WAKEUP_CMD] = 1'b0;
   assign ctrl_view[BIT_BUS_RESET_FLAG] = bus_reset_flag_reg;
   assign ctrl_view[BIT_RESUME_FLAG] = resume_flag_reg;
   assign ctrl_view[BIT_PS2_DATA_IN] = pin_sync_reg[0];
   assign ctrl_view[BIT_PS2_CLOCK_IN] = pin_sync_reg[1];
   assign ctrl_view[BIT_PS2_DATA_OUT] = 1'b0;
   assign ctrl_view[BIT_PS2_CLOCK_OUT] = 1'b0;

   // Read multiplexer; unmapped addresses read zero
   // The decode has no side effects; clearing happens on acceptance
   wire logic [7:0] endpoint_view = endpoint_reg &
      ~(8'h01 << BIT_FIFO_WRITE_DIR);
   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_hit(avs_address, IDX_USB_PS2_CTRL_STATUS)) begin
         rdata_next[7:0] = ctrl_view;
      end else if (reg_hit(avs_address, IDX_ENDPOINT_IRQ_STATUS)) begin
         rdata_next[7:0] = endpoint_view;
      end else if (reg_hit(avs_address, IDX_CLOCK_CONTROL)) begin
         rdata_next[7:0] = clock_ctrl_reg;
      end else if (reg_hit(avs_address, IDX_EVENT_STATUS)) begin
         rdata_next[EV_COUNT-1:0] = event_status_reg;
      end else if (reg_hit(avs_address, IDX_EVENT_MASK)) begin
         rdata_next[EV_COUNT-1:0] = event_mask_reg;
      end
   end

   // PS2 mode drives pins open-drain: low when the drive bit is zero
   // The pull-up gives the high level; outside PS2 mode both are released
   pin_drive_t pin_drive_next;
   always_comb begin
      pin_drive_next.data_out = 1'b0;
      pin_drive_next.clock_out = 1'b0;
      pin_drive_next.data_oe_n = ~(endpoint_reg[BIT_PS2_SELECT] &
                                   ~ctrl_wr_reg[BIT_PS2_DATA_OUT]);
      pin_drive_next.clock_oe_n = ~(endpoint_reg[BIT_PS2_SELECT] &
                                    ~ctrl_wr_reg[BIT_PS2_CLOCK_OUT]);
   end

   // Bus handshake: one wait cycle, then the answer for one cycle
   // Read data is latched in the wait cycle and held until the next access
   // Back-to-back requests are answered every second cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~(req & wait_reg);
         if (req & wait_reg) begin
            rdata_reg <= avs_read ? rdata_next : 32'h0000_0000;
         end
      end
   end

   // Engine state tracking and resume timer
   // The bus reset flag follows the engine level one cycle late
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         idle_prev_reg <= 1'b0;
         reset_prev_reg <= 1'b0;
         bus_reset_flag_reg <= 1'b0;
         resume_flag_reg <= 1'b0;
         resume_cnt_reg <= '0;
      end else begin
         idle_prev_reg <= idle_now;
         reset_prev_reg <= sie_status.usb_reset;
         bus_reset_flag_reg <= sie_status.usb_reset;
         resume_flag_reg <= resume_next;
         resume_cnt_reg <= resume_cnt_next;
      end
   end

   // Software-visible control registers
   // Pin-drive bits reset high so the shared pins start released
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_wr_reg <= RST_CTRL_WRITE;
         endpoint_reg <= RST_ENDPOINT;
         clock_ctrl_reg <= RST_CLOCK_CONTROL;
         event_mask_reg <= RST_EVENT_MASK;
      end else begin
         ctrl_wr_reg <= ctrl_wr_next;
         endpoint_reg <= endpoint_next;
         clock_ctrl_reg <= clock_ctrl_next;
         event_mask_reg <= event_mask_next;
      end
   end

   // Sticky events and the interrupt level
   // The level is taken from the next state to save a cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         event_status_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         event_status_reg <= event_status_next;
         irq_reg <= |(event_status_next & event_mask_next);
      end
   end

   // Registered outputs for pins and mode lines
   // Mode lines follow their register bits one cycle later
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_drive_reg <= '{1'b0, 1'b1, 1'b0, 1'b1};
         remote_wakeup_cmd <= 1'b0;
         ps2_select <= 1'b0;
         usb_select <= 1'b0;
         converter_ref_internal <= 1'b1;
         fifo_write_dir <= 1'b0;
         usb_clock_gate <= 1'b0;
         deep_idle_power_save <= 1'b0;
      end else begin
         pin_drive_reg <= pin_drive_next;
         remote_wakeup_cmd <= ctrl_wr_reg[BIT_REMOTE_WAKEUP_CMD];
         ps2_select <= endpoint_reg[BIT_PS2_SELECT];
         usb_select <= endpoint_reg[BIT_USB_SELECT];
         converter_ref_internal <=
            endpoint_reg[BIT_CONVERTER_REF_INTERNAL];
         fifo_write_dir <= endpoint_reg[BIT_FIFO_WRITE_DIR];
         usb_clock_gate <= clock_ctrl_reg[BIT_USB_CLOCK_GATE];
         deep_idle_power_save <=
            clock_ctrl_reg[BIT_DEEP_IDLE_POWER_SAVE];
      end
   end

   // Ports driven straight from their flip-flops
   assign avs_waitrequest = wait_reg;
   assign avs_readdata = rdata_reg;
   assign pin_drive = pin_drive_reg;
   assign usb_irq = irq_reg;

endmodule
`default_nettype wire

// [usb_ps2_regs_pkg.sv]
// Constants, field positions and carrier types of the USB/PS2 register bank
`default_nettype none
package usb_ps2_regs_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_USB_PS2_CTRL_STATUS = 6'h1a;
   localparam logic [5:0] IDX_ENDPOINT_IRQ_STATUS = 6'h1b;
   localparam logic [5:0] IDX_CLOCK_CONTROL = 6'h1c;
   localparam logic [5:0] IDX_EVENT_STATUS = 6'h20;
   localparam logic [5:0] IDX_EVENT_MASK = 6'h21;

   // Control/status register field positions
   localparam int BIT_BUS_IDLE_FLAG = 0;
   localparam int BIT_REMOTE_WAKEUP_CMD = 1;
   localparam int BIT_BUS_RESET_FLAG = 2;
   localparam int BIT_RESUME_FLAG = 3;
   localparam int BIT_PS2_DATA_IN = 4;
   localparam int BIT_PS2_CLOCK_IN = 5;
   localparam int BIT_PS2_DATA_OUT = 6;
   localparam int BIT_PS2_CLOCK_OUT = 7;

   // Endpoint/mode register field positions
   localparam int BIT_PS2_SELECT = 4;
   localparam int BIT_USB_SELECT = 5;
   localparam int BIT_CONVERTER_REF_INTERNAL = 6;
   localparam int BIT_FIFO_WRITE_DIR = 7;

   // Clock control register field positions
   localparam int BIT_USB_CLOCK_GATE = 3;
   localparam int BIT_DEEP_IDLE_POWER_SAVE = 4;

   // Event status / mask field positions
   localparam int EV_IDLE_CHANGE = 0;
   localparam int EV_BUS_RESET = 1;
   localparam int EV_RESUME = 2;
   localparam int EV_ENDPOINT = 3;
   localparam int EV_COUNT = 4;

   // Reset values
   localparam logic [7:0] RST_CTRL_WRITE = 8'hc0;
   localparam logic [7:0] RST_ENDPOINT = 8'h40;
   localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
   localparam logic [3:0] RST_EVENT_MASK = 4'h0;

   // Timing: resume flag visibility
   localparam int CLK_MHZ = 200;
   localparam int RESUME_HOLD_MS = 20;
   localparam int RESUME_HOLD_CYCLES = RESUME_HOLD_MS * 1000 * CLK_MHZ;
   localparam int RESUME_CNT_W = 23;

   // Status coming from the serial interface engine
   typedef struct packed {
      logic [3:0] endpoint_hit;
      logic usb_reset;
      logic bus_idle;
   } sie_status_t;

   // Drive of the shared D+/CLK and D-/DATA pins
   typedef struct packed {
      logic clock_out;
      logic clock_oe_n;
      logic data_out;
      logic data_oe_n;
   } pin_drive_t;

endpackage
`default_nettype wire

// [usb_ps2_regs_checker.sv]
// Port-level assertions for the USB/PS2 register bank
`default_nettype none
module usb_ps2_regs_checker
   import usb_ps2_regs_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic resetn, // Reset, active low
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire sie_status_t sie_status, // Engine status
   input wire pin_drive_t pin_drive, // Pin drive
   input wire logic remote_wakeup_cmd, // Wakeup command
   input wire logic ps2_select, // PS2 mode
   input wire logic usb_select, // USB mode
   input wire logic converter_ref_internal, // Reference select
   input wire logic fifo_write_dir, // FIFO direction
   input wire logic usb_clock_gate // Clock gate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Completed accesses and grouped mode outputs
   wire rd_ctrl = avs_read && !avs_waitrequest && avs_address == 8'h68;
   wire wr_done = avs_write && !avs_waitrequest;
   wire [3:0] mode = {ps2_select, usb_select, converter_ref_internal,
                      fifo_write_dir};
   // Engine suspend level as sampled one edge back
   logic idle_p1;
   always_ff @(posedge core_clk) begin
      idle_p1 <= sie_status.bus_idle;
   end

   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("Access not answered in one cycle");
   wait_rest_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("Answer without request");
   reset_val_a: assert property ($rose(resetn) |-> converter_ref_internal
      && !ps2_select && !usb_select && avs_waitrequest)
      else $error("Wrong output after reset");
   upper_zero_a: assert property (!avs_waitrequest |->
      avs_readdata[31:8] == 24'h00_0000) else $error("Upper read bits set");
   wo_zero_a: assert property (rd_ctrl |-> avs_readdata[7:6] == 2'b00
      && !avs_readdata[1]) else $error("Write-only bit read back");
   idle_read_a: assert property (rd_ctrl && idle_p1 == $past(idle_p1)
      && idle_p1 == $past(idle_p1, 2) |-> avs_readdata[0] == idle_p1)
      else $error("Suspend flag not read back");
   pin_idle_a: assert property (!ps2_select [*2] |-> pin_drive.data_oe_n
      && pin_drive.clock_oe_n) else $error("Pin driven outside PS2 mode");
   pin_low_a: assert property (!pin_drive.data_out && !pin_drive.clock_out)
      else $error("Open-drain pin driven high");
   wake_src_a: assert property ($changed(remote_wakeup_cmd) |->
      $past(wr_done && avs_address == 8'h68, 2))
      else $error("Wakeup changed without write");
   mode_src_a: assert property ($changed(mode) |->
      $past(wr_done && avs_address == 8'h6c, 2))
      else $error("Mode changed without write");
   gate_src_a: assert property ($changed(usb_clock_gate) |->
      $past(wr_done && avs_address == 8'h70, 2))
      else $error("Clock gate changed without write");
endmodule

bind usb_ps2_status_control_regs usb_ps2_regs_checker u_chk (
   .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .sie_status(sie_status),
   .pin_drive(pin_drive), .remote_wakeup_cmd(remote_wakeup_cmd),
   .ps2_select(ps2_select), .usb_select(usb_select),
   .converter_ref_internal(converter_ref_internal),
   .fifo_write_dir(fifo_write_dir), .usb_clock_gate(usb_clock_gate)
);
`default_nettype wire

// [usb_ps2_host_model.sv]
// Far-side model: pulled-up shared pins and engine status from the host
`default_nettype none
module usb_ps2_host_model
   import usb_ps2_regs_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire pin_drive_t pin_drive, // Device pin drive
   output logic data_pin_in, // DATA wire level
   output logic clock_pin_in, // CLK wire level
   output var sie_status_t sie_status // Engine status
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins float up to the pull-up level
   assign data_pin_in = pin_drive.data_oe_n ? 1'b1 : pin_drive.data_out;
   assign clock_pin_in = pin_drive.clock_oe_n ? 1'b1 : pin_drive.clock_out;
   initial sie_status = '0;
   // Host-caused bus states, called just after a rising edge
   task automatic set_idle(input logic v);
      sie_status.bus_idle <= v;
   endtask
   task automatic set_rst(input logic v);
      sie_status.usb_reset <= v;
   endtask
   task automatic hit(input int e);
      sie_status.endpoint_hit[e] <= 1'b1;
      @(posedge core_clk);
      sie_status.endpoint_hit <= 4'h0;
   endtask
endmodule
`default_nettype wire

// [usb_ps2_status_control_regs_tb.sv]
// Self-checking bench for the USB/PS2 register bank
`default_nettype none
module usb_ps2_status_control_regs_tb;
   import usb_ps2_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 16;
   logic core_clk = 0;
   logic resetn = 0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, usb_irq, data_pin_in, clock_pin_in;
   logic usb_int_enable = 1;
   logic stack_full = 0;
   sie_status_t sie_status;
   pin_drive_t pin_drive;
   wire logic [6:0] outs;
   int errors = 0;
   int check_count = 0;
   // Reference model state
   logic idle_m = 0, rst_m = 0, res_m = 0;
   logic [7:0] ctl_m = 8'hc0, ep_m = 8'h40, sc_m = 8'h00;
   logic [3:0] ev_m = 4'h0, mk_m = 4'h0;
   logic [7:0] addrs[$] = '{8'h68, 8'h6c, 8'h70, 8'h80, 8'h84, 8'h88, 8'h69};

   usb_ps2_status_control_regs #(.RESUME_HOLD(HOLD)) DUT (
      .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sie_status(sie_status), .usb_int_enable(usb_int_enable),
      .stack_full(stack_full), .data_pin_in(data_pin_in),
      .clock_pin_in(clock_pin_in), .pin_drive(pin_drive),
      .remote_wakeup_cmd(outs[6]), .ps2_select(outs[5]),
      .usb_select(outs[4]), .converter_ref_internal(outs[3]),
      .fifo_write_dir(outs[2]), .usb_clock_gate(outs[1]),
      .deep_idle_power_save(outs[0]), .usb_irq(usb_irq));
   usb_ps2_host_model host (.core_clk(core_clk), .pin_drive(pin_drive),
      .data_pin_in(data_pin_in), .clock_pin_in(clock_pin_in),
      .sie_status(sie_status));

   initial forever #2.5 core_clk = ~core_clk;

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   // Model of register reads and writes
   function automatic logic [7:0] m_rd(input logic [7:0] a);
      logic dai;
      logic cki;
      dai = !(ep_m[4] && !ctl_m[6]);
      cki = !(ep_m[4] && !ctl_m[7]);
      case (a)
         8'h68: return {2'b00, cki, dai, res_m, rst_m, 1'b0, idle_m};
         8'h6c: return {1'b0, ep_m[6:0]};
         8'h70: return sc_m;
         8'h80: return {4'h0, ev_m};
         8'h84: return {4'h0, mk_m};
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [6:0] m_outs();
      return {ctl_m[1], ep_m[4], ep_m[5], ep_m[6], ep_m[7], sc_m[3], sc_m[4]};
   endfunction
   // One Avalon-MM access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 50) begin
            errors++;
            summarize();
         end
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 0;
      avs_write <= 0;
      @(posedge core_clk);
   endtask
   task automatic wm(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1, a, d, q);
      if (avs_byteenable[0] && a == 8'h68)
         ctl_m = d;
      if (avs_byteenable[0] && a == 8'h6c)
         ep_m = d;
      if (avs_byteenable[0] && a == 8'h70)
         sc_m = d & 8'h18;
      if (avs_byteenable[0] && a == 8'h84)
         mk_m = d[3:0];
      repeat (2) @(posedge core_clk);
      chk("outputs", m_outs(), outs);
   endtask
   task automatic rm(input logic [7:0] a);
      logic [7:0] q;
      bus(0, a, 8'h00, q);
      chk($sformatf("reg %h", a), m_rd(a), q);
      if (a == 8'h80)
         ev_m = 4'h0;
   endtask
   // Let events reach the status and the interrupt line
   task automatic settle();
      repeat (4) @(posedge core_clk);
      chk("irq", {7'h0, |(ev_m & mk_m)}, {7'h0, usb_irq});
   endtask
   task automatic idle(input logic v);
      if (v != idle_m)
         ev_m[0] = 1;
      if (idle_m && !v)
         ev_m[2] = 1;
      if (idle_m && !v)
         res_m = 1;
      if (v)
         res_m = 0;
      idle_m = v;
      host.set_idle(v);
      settle();
   endtask
   task automatic ureset(input logic v);
      if (v && !rst_m)
         ev_m[1] = 1;
      rst_m = v;
      host.set_rst(v);
      settle();
   endtask
   task automatic hit(input int e);
      ep_m[e] = 1;
      if (usb_int_enable && !stack_full)
         ev_m[3] = 1;
      host.hit(e);
      settle();
   endtask

   initial begin
      void'($urandom(84358));
      repeat (2) @(posedge core_clk);
      resetn <= 1;
      @(posedge core_clk);
      chk("reset outputs", m_outs(), outs);
      foreach (addrs[i]) rm(addrs[i]);
      repeat (4) begin
         wm(8'h6c, 8'($urandom));
         rm(8'h6c);
         wm(8'h70, 8'($urandom));
         rm(8'h70);
      end
      wm(8'h6c, 8'h10);
      wm(8'h68, 8'hff);
      rm(8'h68);
      repeat (400) @(posedge core_clk);
      wm(8'h68, 8'h80);
      repeat (4) @(posedge core_clk);
      rm(8'h68);
      wm(8'h68, 8'h00);
      repeat (4) @(posedge core_clk);
      rm(8'h68);
      wm(8'h68, 8'hc0);
      avs_byteenable <= 4'h0;
      wm(8'h6c, 8'hff);
      avs_byteenable <= 4'h1;
      wm(8'h88, 8'hff);
      rm(8'h6c);
      wm(8'h6c, 8'h00);
      wm(8'h84, 8'h0f);
      wm(8'h70, 8'h08);
      idle(1);
      rm(8'h68);
      rm(8'h80);
      settle();
      idle(0);
      rm(8'h68);
      repeat (HOLD - 10) @(posedge core_clk);
      rm(8'h68);
      repeat (4) @(posedge core_clk);
      res_m = 0;
      rm(8'h68);
      rm(8'h80);
      ureset(1);
      rm(8'h68);
      ureset(0);
      rm(8'h80);
      for (int e = 0; e < 4; e++) begin
         stack_full <= e[0];
         usb_int_enable <= (e == 3) ? 1'($urandom) : (e != 0);
         @(posedge core_clk);
         hit(e);
      end
      rm(8'h6c);
      rm(8'h80);
      wm(8'h6c, 8'h00);
      rm(8'h6c);
      wm(8'h84, 8'h00);
      idle(1);
      idle(0);
      idle(1);
      rm(8'h68);
      rm(8'h80);
      summarize();
   end
endmodule
`default_nettype wire
